//--- src/dmacl_regs.svh
// register offsets, control layout, descriptor layout and step sizes of the dma channel
// Operation
// - each move reads source, then writes destination
// - control, length, three 24-bit pointers held
// - step field: fixed, increment, decrement, reserved
// - width field: byte, word, quad; steps 1,2,4
// - length drops by one per move
// - zero length closes the buffer
// - descriptor fields at offsets 0,2,4,8,c
// - software enable runs channel in direct mode
// - list pointer write fetches descriptor, starts list
// - repeat bit suppresses descriptor write-back
// - chain bit picks listed pointer, else +16
// - buffer-end enable raises interrupt on closure
// - frame end signalled while length equals one
// - early peripheral frame end sets frame-end bit
// - stop bit halts after advancing list pointer
// - command bits driven on first transfer
// - command field loaded, replaced by peripheral status
// - direct mode watermark interrupt on low length
// - request starts move; acknowledge and command strobe
// - frame-end request answered by acknowledge, status strobe
// - closure clears enable, writes control back in list mode
`ifndef DMACL_REGS_SVH
`define DMACL_REGS_SVH
`define DMACL_OFF_CTRL 8'h00
`define DMACL_OFF_LEN 8'h04
`define DMACL_OFF_DST 8'h08
`define DMACL_OFF_SRC 8'h0c
`define DMACL_OFF_LIST 8'h10
`define DMACL_OFF_STAT 8'h14
`define DMACL_OFF_WMARK 8'h18
`define DMACL_DESC_CTRL 24'h00_0000
`define DMACL_DESC_LEN 24'h00_0002
`define DMACL_DESC_DST 24'h00_0004
`define DMACL_DESC_SRC 24'h00_0008
`define DMACL_DESC_NEXT 24'h00_000c
`define DMACL_DESC_STRIDE 24'h00_0010
`define DMACL_FETCH_LAST 3'h4
`define DMACL_STEP_FIXED 2'h0
`define DMACL_STEP_INC 2'h1
`define DMACL_STEP_DEC 2'h2
`define DMACL_SIZE_BYTE 2'h0
`define DMACL_SIZE_WORD 2'h1
`define DMACL_SIZE_QUAD 2'h2
`define DMACL_AMOUNT_BYTE 24'h00_0001
`define DMACL_AMOUNT_WORD 24'h00_0002
`define DMACL_AMOUNT_QUAD 24'h00_0004
`define DMACL_CTRL_RESET 16'h0000
`define DMACL_LEN_ONE 16'h0001
`endif

//--- src/dmacl_pkg.sv
// types shared by the dma channel: states, control word, bus and peripheral carriers
package dmacl_pkg;
	typedef enum {st_idle, st_fetch, st_read, st_write, st_wait_eof, st_status, st_close,
		st_wback, st_advance} dmacl_state_t;
	typedef struct packed {
		logic [3:0] command_status_field;
		logic halt;
		logic frame_end;
		logic chain_to_listed_pointer;
		logic buffer_end_irq_enable;
		logic [1:0] source_step_mode;
		logic [1:0] destination_step_mode;
		logic [1:0] transfer_width;
		logic loop;
		logic channel_enable;
	} dmacl_ctrl_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [23:0] addr;
		logic [31:0] wdata;
	} dmacl_mem_t;
	typedef struct packed {
		logic ack;
		logic command_valid_strobe;
		logic [3:0] peripheral_command_bus;
		logic frame_end_to_peripheral;
		logic read_status_strobe;
	} dmacl_per_t;
endpackage

//--- src/dmacl_channel.sv
// one dma channel: register port, memory bus master, peripheral handshake, descriptor fetch
`include "dmacl_regs.svh"
module dmacl_channel (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output dmacl_pkg::dmacl_mem_t mem_out, // memory request, held until ack
	input wire logic mem_ack, // memory completes request
	input wire logic [31:0] mem_rdata, // memory read data with ack
	input wire logic per_req, // peripheral transfer request
	input wire logic per_req_eof, // peripheral frame-end request
	input wire logic [3:0] peripheral_status_bus, // peripheral status
	output dmacl_pkg::dmacl_per_t per_out, // peripheral handshake group
	output logic irq // one-cycle interrupt pulse
);
	import dmacl_pkg::*;

	dmacl_state_t state, next_state;
	dmacl_ctrl_t ctrl, next_ctrl;
	logic [15:0] len, next_len;
	logic [23:0] dst, next_dst;
	logic [23:0] src, next_src;
	logic [23:0] list_ptr, next_list_ptr;
	logic [23:0] link_next, next_link_next;
	logic [31:0] data, next_data;
	logic [2:0] fetch_idx, next_fetch_idx;
	logic linked, next_linked;
	logic first_xfer, next_first_xfer;
	logic early, next_early;
	logic next_irq;
	logic [31:0] next_rdata;
	logic [15:0] len_dec;
	logic wmark_hit;
	logic in_read, in_write;

	// pointer step by mode and width; the reserved mode code leaves the pointer alone, the reserved width code steps by a byte
	function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic [1:0] mode,
		input logic [1:0] width);
		logic [23:0] amount;
		case (width)
			`DMACL_SIZE_WORD: amount = `DMACL_AMOUNT_WORD;
			`DMACL_SIZE_QUAD: amount = `DMACL_AMOUNT_QUAD;
			default: amount = `DMACL_AMOUNT_BYTE;
		endcase
		case (mode)
			`DMACL_STEP_INC: step_ptr = p + amount;
			`DMACL_STEP_DEC: step_ptr = p - amount;
			default: step_ptr = p;
		endcase
	endfunction

	// descriptor field offset by fetch step
	function automatic logic [23:0] desc_off(input logic [2:0] idx);
		case (idx)
			3'h1: desc_off = `DMACL_DESC_LEN;
			3'h2: desc_off = `DMACL_DESC_DST;
			3'h3: desc_off = `DMACL_DESC_SRC;
			3'h4: desc_off = `DMACL_DESC_NEXT;
			default: desc_off = `DMACL_DESC_CTRL;
		endcase
	endfunction

	assign in_read = (state == st_read);
	assign in_write = (state == st_write);
	assign len_dec = len - `DMACL_LEN_ONE;
	// watermark only in direct mode and only when programmed nonzero
	assign wmark_hit = !linked && (list_ptr[23:16] != 8'h00) && ctrl.buffer_end_irq_enable
		&& (len_dec[15:8] == 8'h00) && (len_dec[7:0] == list_ptr[23:16]);

	// memory master: one request per state, held until the memory acks
	always_comb begin
		mem_out = '0;
		case (state)
			st_fetch: begin
				mem_out.req = 1'b1;
				mem_out.size = (fetch_idx < 3'h2) ? `DMACL_SIZE_WORD : `DMACL_SIZE_QUAD;
				mem_out.addr = list_ptr + desc_off(fetch_idx);
			end
			st_read: begin
				mem_out.req = 1'b1;
				mem_out.size = ctrl.transfer_width;
				mem_out.addr = src;
			end
			st_write: begin
				mem_out.req = 1'b1;
				mem_out.we = 1'b1;
				mem_out.size = ctrl.transfer_width;
				mem_out.addr = dst;
				mem_out.wdata = data;
			end
			st_wback: begin
				mem_out.req = 1'b1;
				mem_out.we = 1'b1;
				mem_out.size = `DMACL_SIZE_WORD;
				mem_out.addr = list_ptr;
				mem_out.wdata = {16'h0000, ctrl};
			end
			default: begin
			end
		endcase
	end

	// peripheral side: acknowledge covers the whole move and the status read
	always_comb begin
		per_out = '0;
		per_out.ack = in_read || in_write || (state == st_status);
		per_out.command_valid_strobe = in_write && first_xfer;
		if ((in_read || in_write) && first_xfer) begin
			per_out.peripheral_command_bus = ctrl.command_status_field;
		end
		per_out.frame_end_to_peripheral = (in_read || in_write) && ctrl.frame_end
			&& (len == `DMACL_LEN_ONE);
		per_out.read_status_strobe = (state == st_status);
	end

	// channel sequencer and register file next values
	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_len = len;
		next_dst = dst;
		next_src = src;
		next_list_ptr = list_ptr;
		next_link_next = link_next;
		next_data = data;
		next_fetch_idx = fetch_idx;
		next_linked = linked;
		next_first_xfer = first_xfer;
		next_early = early;
		next_irq = 1'b0;
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`DMACL_OFF_CTRL: next_rdata = {16'h0000, ctrl};
				`DMACL_OFF_LEN: next_rdata = {16'h0000, len};
				`DMACL_OFF_DST: next_rdata = {8'h00, dst};
				`DMACL_OFF_SRC: next_rdata = {8'h00, src};
				`DMACL_OFF_LIST: next_rdata = {8'h00, list_ptr};
				`DMACL_OFF_STAT: next_rdata = {28'h000_0000, early, first_xfer, linked,
					state != st_idle};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		case (state)
			st_idle: begin
				// software owns the registers only while idle; a write delays a start by a cycle
				if (reg_wr) begin
					case (reg_addr)
						`DMACL_OFF_CTRL: begin
							next_ctrl = reg_wdata[15:0];
							next_linked = 1'b0;
							next_first_xfer = 1'b1;
						end
						`DMACL_OFF_LEN: next_len = reg_wdata[15:0];
						`DMACL_OFF_DST: next_dst = reg_wdata[23:0];
						`DMACL_OFF_SRC: next_src = reg_wdata[23:0];
						`DMACL_OFF_LIST: begin
							next_list_ptr = reg_wdata[23:0];
							next_fetch_idx = 3'h0;
							next_state = st_fetch;
						end
						`DMACL_OFF_WMARK: next_list_ptr[23:16] = reg_wdata[7:0];
						default: begin
						end
					endcase
				end else if (ctrl.channel_enable) begin
					if (len == 16'h0000) begin
						next_state = st_close;
					end else if (per_req_eof) begin
						next_ctrl.frame_end = 1'b1;
						next_early = 1'b1;
						next_state = st_status;
					end else if (per_req) begin
						next_state = st_read;
					end
				end
			end
			st_fetch: begin
				if (mem_ack) begin
					case (fetch_idx)
						3'h0: next_ctrl = mem_rdata[15:0];
						3'h1: next_len = mem_rdata[15:0];
						3'h2: next_dst = mem_rdata[23:0];
						3'h3: next_src = mem_rdata[23:0];
						default: next_link_next = mem_rdata[23:0];
					endcase
					next_fetch_idx = 3'(fetch_idx + 3'h1);
					if (fetch_idx == `DMACL_FETCH_LAST) begin
						next_linked = ctrl.channel_enable;
						next_first_xfer = 1'b1;
						next_state = st_idle;
					end
				end
			end
			st_read: begin
				if (mem_ack) begin
					next_data = mem_rdata;
					next_state = st_write;
				end
			end
			st_write: begin
				// pointers and count move only once the destination has taken the data
				if (mem_ack) begin
					next_src = step_ptr(src, ctrl.source_step_mode, ctrl.transfer_width);
					next_dst = step_ptr(dst, ctrl.destination_step_mode,
						ctrl.transfer_width);
					next_len = len_dec;
					next_first_xfer = 1'b0;
					next_irq = wmark_hit;
					if (len_dec != 16'h0000) begin
						next_state = st_idle;
					end else if (ctrl.frame_end) begin
						next_state = st_wait_eof;
					end else begin
						next_state = st_close;
					end
				end
			end
			st_wait_eof: begin
				if (per_req_eof) begin
					next_state = st_status;
				end
			end
			st_status: begin
				next_ctrl.command_status_field = peripheral_status_bus;
				next_state = st_close;
			end
			st_close: begin
				next_ctrl.channel_enable = 1'b0;
				next_irq = ctrl.buffer_end_irq_enable || early;
				next_early = 1'b0;
				next_first_xfer = 1'b1;
				// repeat lists keep their descriptors untouched
				if (linked && !ctrl.loop) begin
					next_state = st_wback;
				end else begin
					next_state = st_advance;
				end
			end
			st_wback: begin
				if (mem_ack) begin
					next_state = st_advance;
				end
			end
			st_advance: begin
				next_state = st_idle;
				if (linked) begin
					if (ctrl.chain_to_listed_pointer) begin
						next_list_ptr = link_next;
					end else begin
						next_list_ptr = list_ptr + `DMACL_DESC_STRIDE;
					end
					if (!ctrl.halt) begin
						next_fetch_idx = 3'h0;
						next_state = st_fetch;
					end
				end
			end
			default: next_state = st_idle;
		endcase
	end

	// register everything; reset leaves the channel disabled and in direct mode
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			ctrl <= `DMACL_CTRL_RESET;
			len <= 16'h0000;
			dst <= 24'h00_0000;
			src <= 24'h00_0000;
			list_ptr <= 24'h00_0000;
			link_next <= 24'h00_0000;
			data <= 32'h0000_0000;
			fetch_idx <= 3'h0;
			linked <= 1'b0;
			first_xfer <= 1'b1;
			early <= 1'b0;
			irq <= 1'b0;
			reg_rdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			len <= next_len;
			dst <= next_dst;
			src <= next_src;
			list_ptr <= next_list_ptr;
			link_next <= next_link_next;
			data <= next_data;
			fetch_idx <= next_fetch_idx;
			linked <= next_linked;
			first_xfer <= next_first_xfer;
			early <= next_early;
			irq <= next_irq;
			reg_rdata <= next_rdata;
		end
	end

	// checks kept beside the logic
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence s_write_done;
		in_write && mem_ack;
	endsequence
	sequence s_eof_answer;
		(state == st_wait_eof) && per_req_eof;
	endsequence

	property p_read_first;
		$rose(in_write) |-> $past(in_read) && $past(mem_ack);
	endproperty
	a_read_first: assert property (p_read_first) else $error("write without prior read");

	property p_len_dec;
		s_write_done |=> len == $past(len) - 16'h0001;
	endproperty
	a_len_dec: assert property (p_len_dec) else $error("length not decremented by one");

	property p_quad_inc;
		s_write_done ##0 (ctrl.transfer_width == 2'h2 && ctrl.source_step_mode == 2'h1)
			|=> src == $past(src) + 24'h00_0004;
	endproperty
	a_quad_inc: assert property (p_quad_inc) else $error("quad source step wrong");

	property p_dst_dec_byte;
		s_write_done ##0 (ctrl.transfer_width == 2'h0 && ctrl.destination_step_mode == 2'h2)
			|=> dst == $past(dst) - 24'h00_0001;
	endproperty
	a_dst_dec_byte: assert property (p_dst_dec_byte) else $error("byte dest step wrong");

	property p_hold_until_ack;
		in_read && !mem_ack |=> in_read && src == $past(src) && len == $past(len);
	endproperty
	a_hold_until_ack: assert property (p_hold_until_ack) else $error("moved before ack");

	property p_close_on_zero;
		s_write_done ##0 (len == 16'h0001) |=> state == st_wait_eof || state == st_close;
	endproperty
	a_close_on_zero: assert property (p_close_on_zero) else $error("no closure at zero");

	property p_fetch_addr;
		state == st_fetch && fetch_idx == 3'h3 |-> mem_out.addr == list_ptr + 24'h00_0008;
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("source field address wrong");

	property p_list_start;
		state == st_idle && reg_wr && reg_addr == 8'h10 |=> state == st_fetch && fetch_idx == 3'h0;
	endproperty
	a_list_start: assert property (p_list_start) else $error("list write did not fetch");

	property p_close_irq;
		state == st_close && ctrl.buffer_end_irq_enable |=> irq && !ctrl.channel_enable;
	endproperty
	a_close_irq: assert property (p_close_irq) else $error("closure irq or enable wrong");

	property p_no_wback_loop;
		state == st_close && ctrl.loop |=> state == st_advance ##1 state != st_wback;
	endproperty
	a_no_wback_loop: assert property (p_no_wback_loop) else $error("repeat list written");

	property p_chain;
		state == st_advance && linked && ctrl.chain_to_listed_pointer
			|=> list_ptr == $past(link_next);
	endproperty
	a_chain: assert property (p_chain) else $error("chained pointer not taken");

	property p_halt;
		state == st_advance && linked && ctrl.halt |=> state == st_idle [*2];
	endproperty
	a_halt: assert property (p_halt) else $error("halted list fetched");

	property p_status_answer;
		s_eof_answer |=> per_out.read_status_strobe && per_out.ack ##1 state == st_close;
	endproperty
	a_status_answer: assert property (p_status_answer) else $error("status strobe missing");

	property p_cmd_valid;
		per_out.command_valid_strobe |-> first_xfer && in_write
			&& per_out.peripheral_command_bus == ctrl.command_status_field;
	endproperty
	a_cmd_valid: assert property (p_cmd_valid) else $error("command strobe wrong");

	property p_wmark;
		s_write_done ##0 wmark_hit |=> irq;
	endproperty
	a_wmark: assert property (p_wmark) else $error("watermark irq missing");
endmodule

//--- sim/dmacl_partner.sv
// memory model for the channel's bus: byte store, random ack delay, scrambled idle data
module dmacl_partner (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire dmacl_pkg::dmacl_mem_t mem_out, // request from the channel
	output logic mem_ack, // completion, one cycle
	output logic [31:0] mem_rdata // read data with ack
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmacl_pkg::*;
	logic [7:0] m [int];
	int wait_n;
	int a;
	function automatic logic [7:0] rd8(int x);
		return m.exists(x) ? m[x] : 8'h5a;
	endfunction
	// answer after 0..2 idle cycles; slow answers test that requests are held
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			wait_n <= 0;
		end else if (mem_ack || mem_out.req !== 1'b1) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata; // no stale data outside an answer
			wait_n <= $urandom_range(2);
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
			mem_rdata <= ~mem_rdata;
		end else begin
			a = int'(mem_out.addr);
			mem_ack <= 1'b1;
			mem_rdata <= {rd8(a + 3), rd8(a + 2), rd8(a + 1), rd8(a)};
			if (mem_out.we) begin
				for (int j = 0; j < (1 << mem_out.size); j++) begin
					m[a + j] = mem_out.wdata[8*j +: 8];
				end
			end
		end
	end
endmodule

//--- sim/dmacl_channel_tb_top.sv
// self-checking bench for the dma channel: direct, frame end, watermark, linked list
`include "dmacl_regs.svh"
module dmacl_channel_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dmacl_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic per_req = 1'b0;
	logic per_req_eof = 1'b0;
	logic [3:0] peripheral_status_bus = 4'h0;
	logic [31:0] reg_rdata;
	logic [31:0] mem_rdata;
	logic mem_ack;
	logic irq;
	logic fe_d;
	logic cv_d;
	logic [3:0] last_cmd;
	dmacl_mem_t mem_out;
	dmacl_per_t per_out;
	int n_fail, compares, n_irq, n_cmd, n_fe;
	logic [7:0] src_copy [int];
	logic [7:0] exp_m [int];
	// 125 MHz system clock
	always #4 mclk = ~mclk;
	dmacl_channel i_dmacl_channel (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .per_req(per_req),
		.per_req_eof(per_req_eof), .peripheral_status_bus(peripheral_status_bus),
		.per_out(per_out), .irq(irq));
	dmacl_partner i_dmacl_partner (.mclk(mclk), .nrst(nrst), .mem_out(mem_out),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// event counters, sampled mid-cycle where outputs are settled
	always @(negedge mclk) begin
		if (irq === 1'b1) n_irq++;
		// command strobe stands through the whole first write; count its rising edge only
		if (per_out.command_valid_strobe === 1'b1 && cv_d !== 1'b1) begin
			n_cmd++;
			last_cmd = per_out.peripheral_command_bus;
		end
		if (per_out.frame_end_to_peripheral === 1'b1 && fe_d !== 1'b1) n_fe++;
		fe_d = per_out.frame_end_to_peripheral;
		cv_d = per_out.command_valid_strobe;
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang(string what);
		n_fail++;
		$display("mismatch %s expected event seen none", what);
		print_verdict();
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	// bounded wait for acknowledge (sel 0) or status strobe (sel 1)
	task automatic await(int sel, logic lvl);
		logic s;
		for (int k = 0; k < 200; k++) begin
			@(negedge mclk);
			s = sel == 0 ? per_out.ack : per_out.read_status_strobe;
			if (s === lvl) return;
		end
		hang("handshake");
	endtask
	// one request, held until acknowledged, dropped on the next edge
	task automatic move();
		int n;
		@(posedge mclk);
		per_req <= 1'b1;
		await(0, 1'b1);
		@(posedge mclk);
		per_req <= 1'b0;
		n = 1;
		while (n < 50) begin
			@(negedge mclk);
			if (per_out.ack !== 1'b1) break;
			n++;
		end
		if (n >= 50) hang("ack release");
		else check("ack_cycles", n >= 2, 1);
	endtask
	task automatic close_eof(logic [3:0] st);
		@(posedge mclk);
		per_req_eof <= 1'b1;
		peripheral_status_bus <= st;
		await(1, 1'b1);
		@(posedge mclk);
		per_req_eof <= 1'b0;
		peripheral_status_bus <= ~st; // status no longer held
	endtask
	// closure is over once enable is clear and the engine is idle
	task automatic wait_done();
		logic [31:0] c, s;
		for (int k = 0; k < 40; k++) begin
			rd(`DMACL_OFF_CTRL, c);
			rd(`DMACL_OFF_STAT, s);
			if (c[0] === 1'b0 && s[0] === 1'b0) begin
				repeat (3) @(posedge mclk);
				return;
			end
		end
		hang("closure");
	endtask
	task automatic put(int a, logic [31:0] v, int n);
		for (int j = 0; j < n; j++) begin
			i_dmacl_partner.m[a + j] = v[8*j +: 8];
			src_copy[a + j] = v[8*j +: 8];
		end
	endtask
	function automatic int stp(logic [1:0] md, int nb);
		return md == 2'h1 ? nb : md == 2'h2 ? -nb : 0;
	endfunction
	// reference mover: fills the source and predicts destination bytes and pointers
	task automatic model(logic [1:0] w, ds, ss, int n, inout int sa, da);
		int nb;
		nb = 1 << w;
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < nb; j++) begin
				if (!src_copy.exists(sa + j)) put(sa + j, $urandom, 1);
				exp_m[da + j] = src_copy[sa + j];
			end
			sa += stp(ss, nb);
			da += stp(ds, nb);
		end
	endtask
	task automatic cmp_dst();
		foreach (exp_m[a]) check("dst_data", i_dmacl_partner.m[a], exp_m[a]);
		exp_m.delete();
	endtask
	task automatic run_direct(logic [1:0] w, ds, ss, int len, nmv, logic ie, fe, logic [7:0] wm);
		int sa, da, irq0, cmd0, fe0, hits, dec;
		logic [15:0] c;
		logic [3:0] cmd, st;
		logic early;
		logic [31:0] v;
		sa = 32'h1040;
		da = 32'h3040;
		cmd = 4'($urandom);
		st = 4'($urandom);
		early = nmv < len;
		c = {cmd, 1'b0, fe, 1'b0, ie, ss, ds, w, 1'b0, 1'b1};
		wr(`DMACL_OFF_DST, da);
		wr(`DMACL_OFF_SRC, sa);
		wr(`DMACL_OFF_LEN, len);
		wr(`DMACL_OFF_WMARK, wm);
		irq0 = n_irq;
		cmd0 = n_cmd;
		fe0 = n_fe;
		wr(`DMACL_OFF_CTRL, c);
		model(w, ds, ss, nmv, sa, da);
		hits = 0;
		for (int i = 0; i < nmv; i++) begin
			move();
			dec = len - 1 - i;
			if (ie && wm != 0 && dec < 256 && dec[7:0] == wm) hits++;
		end
		if (fe || early) close_eof(st);
		wait_done();
		cmp_dst();
		c[0] = 1'b0;
		if (early) c[10] = 1'b1;
		if (fe || early) c[15:12] = st;
		rd(`DMACL_OFF_CTRL, v);
		check("ctrl", v, c);
		rd(`DMACL_OFF_LEN, v);
		check("len", v, len - nmv);
		rd(`DMACL_OFF_DST, v);
		check("dst_ptr", v, da & 32'h00ff_ffff);
		rd(`DMACL_OFF_SRC, v);
		check("src_ptr", v, sa & 32'h00ff_ffff);
		rd(`DMACL_OFF_LIST, v);
		check("watermark", v[31:16], {8'h00, wm});
		check("irq_count", n_irq - irq0, hits + (ie || early));
		check("cmd_count", n_cmd - cmd0, nmv > 0);
		if (nmv > 0) check("cmd", last_cmd, cmd);
		check("eof_count", n_fe - fe0, fe && !early);
		$display("test direct w%0d ds%0d ss%0d len%0d done", w, ds, ss, len);
	endtask
	// two descriptors: chained, written back; then looped, halted, advanced by 16
	task automatic run_list();
		logic [15:0] ca, cb;
		logic [31:0] v;
		int sa, da, sb, db, irq0, cmd0;
		ca = {4'h5, 1'b0, 1'b0, 1'b1, 1'b1, 2'h1, 2'h1, 2'h2, 1'b0, 1'b1};
		cb = {4'h9, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 2'h0, 2'h1, 1'b1, 1'b1};
		sa = 32'h1100;
		da = 32'h3100;
		sb = 32'h1180;
		db = 32'h3180;
		put(32'h100, ca, 2);
		put(32'h102, 2, 2);
		put(32'h104, da, 4);
		put(32'h108, sa, 4);
		put(32'h10c, 32'h200, 4);
		put(32'h200, cb, 2);
		put(32'h202, 1, 2);
		put(32'h204, db, 4);
		put(32'h208, sb, 4);
		put(32'h20c, 32'h0770, 4);
		model(2'h2, 2'h1, 2'h1, 2, sa, da);
		model(2'h1, 2'h0, 2'h2, 1, sb, db);
		irq0 = n_irq;
		cmd0 = n_cmd;
		wr(`DMACL_OFF_LIST, 32'h100);
		repeat (3) move();
		wait_done();
		cmp_dst();
		v = {i_dmacl_partner.m[32'h101], i_dmacl_partner.m[32'h100]};
		check("wback", v, ca & 16'hfffe);
		v = {i_dmacl_partner.m[32'h201], i_dmacl_partner.m[32'h200]};
		check("loop_desc", v, cb);
		rd(`DMACL_OFF_LIST, v);
		check("list_ptr", v, 32'h210);
		rd(`DMACL_OFF_CTRL, v);
		check("ctrl", v, cb & 16'hfffe);
		rd(`DMACL_OFF_LEN, v);
		check("len", v, 0);
		check("irq_count", n_irq - irq0, 2);
		check("cmd_count", n_cmd - cmd0, 2);
		check("cmd", last_cmd, 4'h9);
		$display("test linked list done");
	endtask
	initial begin
		logic [31:0] v;
		int len;
		void'($urandom(32'hcf2be60c));
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		rd(`DMACL_OFF_CTRL, v);
		check("ctrl_reset", v, `DMACL_CTRL_RESET);
		rd(`DMACL_OFF_STAT, v);
		// out of reset only the first-transfer-pending bit stands
		check("stat_reset", v, 32'h0000_0004);
		wr(8'h1c, 32'hffff_ffff);
		rd(8'h1c, v);
		check("unmapped", v, 0);
		$display("test reset done");
		for (int w = 0; w < 3; w++) begin
			for (int ds = 0; ds < 3; ds++) begin
				len = 2 + $urandom_range(2);
				run_direct(2'(w), 2'(ds), 2'((ds + w) % 3), len, len, w == 1 || ds == 1,
					1'b0, w == 1 ? 8'h01 : 8'h00);
			end
		end
		run_direct(2'h0, 2'h1, 2'h1, 2, 2, 1'b0, 1'b1, 8'h00);
		run_direct(2'h1, 2'h1, 2'h1, 3, 1, 1'b0, 1'b0, 8'h00);
		run_direct(2'h2, 2'h0, 2'h1, 1, 1, 1'b1, 1'b1, 8'h00);
		run_direct(2'h0, 2'h1, 2'h1, 0, 0, 1'b1, 1'b0, 8'h00);
		run_list();
		print_verdict();
	end
endmodule
